// *** rtl/lds_lock_status.sv ***
// lock detect, holdover, DAC flags, status pin muxes and register port
`timescale 1ns/1ns
module lds_lock_status (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire lds_pkg::lds_bus_t    busReq,
    output logic [lds_pkg::DATA_W-1:0] rdData,
    input  wire logic [3:0]           divPulse,
    input  wire logic [2:0]           clkInPin,
    input  wire logic [lds_pkg::DAC_W-1:0] tuneLevel,
    input  wire logic [1:0]           activeInput,
    output logic [2:0]                statusPin,
    output logic [lds_pkg::DAC_W-1:0] tuneDac,
    output logic                      holdover,
    output lds_pkg::lds_div_cfg_t     divCfg
);
    import lds_pkg::*;

    typedef struct packed {
        logic [3:0]            dsA;
        logic [3:0]            dsB;
        logic [3:0]            dsC;
        logic [2:0]            csA;
        logic [2:0]            csB;
        logic [2:0]            csC;
        lds_ctrl_t             ctrl;
        lds_lock_t             lck;
        lds_tune_t             tun;
        lds_mux_t              mux;
        lds_div1_t             div1;
        lds_div2_t             div2;
        lds_fb_t               fb;
        lds_fb_t               cal;
        logic [1:0]            armed;
        logic [1:0]            armR;
        logic [1:0][ERR_W-1:0] err;
        logic [1:0][HITS_W-1:0] hits;
        logic [1:0]            lock;
        lds_ho_t               ho;
        logic [DAC_W-1:0]      dac;
        logic                  dLow;
        logic                  dHigh;
        logic                  dRail;
        logic                  dLocked;
        logic [3:0]            half;
        logic [2:0][TMR_W-1:0] tmr;
        logic [2:0]            los;
        logic [8:0]            calCnt;
        logic [17:0]           n2Out;
        logic [RB_W-1:0]       rb;
        logic [5:0]            rbCnt;
        logic [2:0]            pins;
        logic [DATA_W-1:0]     rdata;
    } lds_st_t;

    lds_st_t          q;
    lds_st_t          d;
    logic [3:0]       dEdge;
    logic [2:0]       cEdge;
    logic [1:0]       cmp;
    logic [1:0]       inWin;
    logic             lock1Flag;
    logic             railCond;
    logic [TMR_W-1:0] losLimit;
    lds_stat_t        stat;
    lds_div2_t        div2W;
    logic             pv;
    logic [DAC_W-1:0] diff;

    // next-state logic for the whole block
    always_comb begin
        d = q;
        // pin inputs pass two flops; the third only serves edge detection
        d.dsA = divPulse;
        d.dsB = q.dsA;
        d.dsC = q.dsB;
        d.csA = clkInPin;
        d.csB = q.csA;
        d.csC = q.csB;
        dEdge = q.dsB & ~q.dsC;
        cEdge = q.csB & ~q.csC;
        cmp = '0;
        inWin = '0;

        // per loop phase window detector, reference edge index 2l, feedback 2l+1
        for (int l = 0; l < 2; l++) begin
            if (dEdge[2*l] && dEdge[2*l+1]) begin
                cmp[l] = 1'b1;
                inWin[l] = q.lck.lockWindowSize != '0;
                d.armed[l] = 1'b0;
            end else if (dEdge[2*l] || dEdge[2*l+1]) begin
                if (q.armed[l] && (q.armR[l] != dEdge[2*l])) begin
                    cmp[l] = 1'b1;
                    inWin[l] = q.err[l] < q.lck.lockWindowSize;
                    d.armed[l] = 1'b0;
                end else begin
                    // first edge arms; same edge twice: the other side is missing a whole period
                    cmp[l] = q.armed[l];
                    d.armed[l] = 1'b1;
                    d.armR[l] = dEdge[2*l];
                    d.err[l] = '0;
                end
            end else if (q.armed[l] && q.err[l] != '1) begin
                d.err[l] = q.err[l] + 1'b1;
            end
            if (cmp[l] && inWin[l]) begin
                if (q.hits[l] < q.lck.lockHoldCount) begin
                    d.hits[l] = q.hits[l] + 1'b1;
                end
                d.lock[l] = d.hits[l] >= q.lck.lockHoldCount;
            end else if (cmp[l]) begin
                d.hits[l] = '0;
                d.lock[l] = 1'b0;
            end
        end

        d.dLow = tuneLevel < q.tun.lowTrip;
        d.dHigh = tuneLevel > q.tun.highTrip;
        d.dRail = d.dLow || d.dHigh;
        diff = (q.dac > tuneLevel) ? q.dac - tuneLevel : tuneLevel - q.dac;
        d.dLocked = q.ctrl.trackEnable && diff <= DAC_NEAR;
        railCond = q.ctrl.railDetectEnable && q.dRail;

        // holdover state; entry on force, lock loss or rail, exit by host or auto
        unique case (q.ho)
            HO_RUN: begin
                if (q.ctrl.holdEnable &&
                    (q.ctrl.forceHoldover || railCond || (q.lock[0] && !d.lock[0]))) begin
                    d.ho = HO_HOLD;
                end
            end
            HO_HOLD: begin
                if (!q.ctrl.holdEnable) begin
                    d.ho = HO_RUN;
                end else if (q.ctrl.autoExit && q.lock[0] && !q.ctrl.forceHoldover &&
                             !railCond) begin
                    d.ho = HO_RUN;
                end
            end
            default: d.ho = HO_RUN;
        endcase

        // DAC steps one LSB per reference period while tracking; holdover with manual select loads the manual value at once
        if (q.ho == HO_HOLD) begin
            if (q.ctrl.manualTuneSelect) begin
                d.dac = q.tun.manualTuneValue;
            end
        end else if (q.ctrl.trackEnable && dEdge[0]) begin
            if (q.dac < tuneLevel) begin
                d.dac = q.dac + 1'b1;
            end else if (q.dac > tuneLevel) begin
                d.dac = q.dac - 1'b1;
            end
        end

        for (int i = 0; i < 4; i++) begin
            if (dEdge[i]) begin
                d.half[i] = ~q.half[i];
            end
        end

        unique case (q.ctrl.lossTimeoutSetting)
            2'h0: losLimit = LOS0_CYC;
            2'h1: losLimit = LOS1_CYC;
            2'h2: losLimit = LOS2_CYC;
            default: losLimit = LOS3_CYC;
        endcase
        for (int i = 0; i < 3; i++) begin
            if (cEdge[i]) begin
                d.tmr[i] = '0;
            end else if (q.tmr[i] < losLimit) begin
                d.tmr[i] = q.tmr[i] + 1'b1;
            end
            d.los[i] = q.ctrl.lossDetectEnable && d.tmr[i] >= losLimit;
        end

        if (q.calCnt != '0) begin
            d.calCnt = q.calCnt - 1'b1;
        end
        d.n2Out = (q.calCnt != '0) ? q.cal.divide : q.fb.divide;

        // readback shifts MSB first, one bit per clock
        if (q.rbCnt != '0) begin
            d.rb = {q.rb[RB_W-2:0], 1'b0};
            d.rbCnt = q.rbCnt - 1'b1;
        end

        lock1Flag = q.lock[0] && q.ho != HO_HOLD;
        stat = '0;
        stat.lock1Raw = q.lock[0];
        stat.lock1Flag = lock1Flag;
        stat.lock2 = q.lock[1];
        stat.holdover = q.ho == HO_HOLD;
        stat.dacLocked = q.dLocked;
        stat.dacRail = q.dRail;
        stat.dacLow = q.dLow;
        stat.dacHigh = q.dHigh;
        stat.loss = q.los;
        stat.calActive = q.calCnt != '0;
        stat.dacValue = q.dac;

        // status pin muxes, registered so the pins never glitch
        for (int i = 0; i < 3; i++) begin
            pv = 1'b0;
            unique case (q.mux.sel[i])
                SEL_LEVEL: pv = q.ctrl.forcedLevel;
                SEL_LOCK1: pv = lock1Flag;
                SEL_LOCK2: pv = q.lock[1];
                SEL_BOTH: pv = lock1Flag && q.lock[1];
                SEL_HOLD: pv = q.ho == HO_HOLD;
                SEL_DACLK: pv = q.dLocked;
                SEL_RAIL: pv = q.dRail;
                SEL_LOW: pv = q.dLow;
                SEL_HIGH: pv = q.dHigh;
                SEL_R1: pv = dEdge[0];
                SEL_N1: pv = dEdge[1];
                SEL_R2: pv = dEdge[2];
                SEL_N2: pv = dEdge[3];
                SEL_R1H: pv = q.half[0];
                SEL_N1H: pv = q.half[1];
                SEL_R2H: pv = q.half[2];
                SEL_N2H: pv = q.half[3];
                SEL_LOS: pv = q.los[i];
                SEL_ACTIVE: pv = activeInput == 2'(i);
                SEL_RB: pv = (q.rbCnt != '0) && q.rb[RB_W-1];
                default: pv = 1'b0;
            endcase
            d.pins[i] = pv;
        end

        // register writes; reserved bits are stored as zero
        div2W = lds_div2_t'(busReq.wdata);
        if (busReq.wr) begin
            case (busReq.addr)
                REG_CTRL: begin
                    d.ctrl = lds_ctrl_t'(busReq.wdata);
                    d.ctrl.rsvd = '0;
                end
                REG_LOCK: begin
                    d.lck = lds_lock_t'(busReq.wdata);
                    d.lck.rsvd = '0;
                end
                REG_TUNE: begin
                    d.tun = lds_tune_t'(busReq.wdata);
                    d.tun.rsvd = '0;
                end
                REG_MUX: begin
                    d.mux = lds_mux_t'(busReq.wdata);
                    d.mux.rsvd = '0;
                end
                REG_DIV1: begin
                    d.div1 = lds_div1_t'(busReq.wdata);
                    d.div1.rsvd = '0;
                end
                REG_DIV2: begin
                    d.div2 = div2W;
                    d.div2.rsvd = '0;
                    if (div2W.prescale < PRE_MIN) begin
                        d.div2.prescale = PRE_MIN;
                    end else if (div2W.prescale > PRE_MAX) begin
                        d.div2.prescale = PRE_MAX;
                    end
                end
                REG_FBCFG: begin
                    d.fb = lds_fb_t'(busReq.wdata);
                    d.fb.rsvd = '0;
                    d.calCnt = 9'(CAL_CYC);
                end
                REG_CALDIV: begin
                    d.cal = lds_fb_t'(busReq.wdata);
                    d.cal.rsvd = '0;
                end
                REG_RBLOAD: begin
                    d.rb = RB_W'(stat);
                    d.rbCnt = 6'(RB_W);
                end
                default: ;
            endcase
        end

        // read data stands in the cycle after the strobe only
        d.rdata = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                REG_CTRL: d.rdata = q.ctrl;
                REG_LOCK: d.rdata = q.lck;
                REG_TUNE: d.rdata = q.tun;
                REG_MUX: d.rdata = q.mux;
                REG_DIV1: d.rdata = q.div1;
                REG_DIV2: d.rdata = q.div2;
                REG_FBCFG: d.rdata = q.fb;
                REG_CALDIV: d.rdata = q.cal;
                REG_STATUS: d.rdata = stat;
                default: d.rdata = '0;
            endcase
        end
    end

    // state register with constant reset values
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.ho <= HO_RUN;
            q.lck <= LOCK_RST;
            q.div2.prescale <= PRE_MIN;
        end else begin
            q <= d;
        end
    end

    assign rdData = q.rdata;
    assign statusPin = q.pins;
    assign tuneDac = q.dac;
    assign holdover = q.ho == HO_HOLD;
    assign divCfg = '{r1: q.div1.r1, n1: q.div1.n1, r2: q.div2.r2,
                      prescale: q.div2.prescale, n2: q.n2Out};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_fbWrite;
        busReq.wr && busReq.addr == REG_FBCFG;
    endsequence
    sequence s_calRun;
        (q.calCnt == 9'(CAL_CYC)) ##1 (q.n2Out == q.cal.divide);
    endsequence

    property p_calStart;
        s_fbWrite |=> s_calRun;
    endproperty
    a_calStart: assert property (p_calStart) else $error("calibration not started");
    property p_calEnd;
        (q.calCnt == '0 && !busReq.wr) |=> q.n2Out == $past(q.fb.divide);
    endproperty
    a_calEnd: assert property (p_calEnd) else $error("normal divide not restored");
    property p_lockDrop;
        (cmp[0] && !inWin[0]) |=> !q.lock[0];
    endproperty
    a_lockDrop: assert property (p_lockDrop) else $error("lock held after miss");
    property p_cntClear;
        (cmp[1] && !inWin[1]) |=> q.hits[1] == '0;
    endproperty
    a_cntClear: assert property (p_cntClear) else $error("count not cleared");
    property p_lockRise;
        $rose(q.lock[1]) |-> $past(cmp[1] && inWin[1]) && q.hits[1] >= q.lck.lockHoldCount;
    endproperty
    a_lockRise: assert property (p_lockRise) else $error("lock before hold count");
    property p_oneCmp;
        cmp[0] |-> (dEdge[0] && dEdge[1]) || q.armed[0];
    endproperty
    a_oneCmp: assert property (p_oneCmp) else $error("compare without edge");
    property p_holdMask;
        (q.ho == HO_HOLD && q.mux.sel[2] == SEL_LOCK1) |=> !statusPin[2];
    endproperty
    a_holdMask: assert property (p_holdMask) else $error("lock shown in holdover");
    property p_holdPin;
        q.mux.sel[1] == SEL_HOLD |=> statusPin[1] == $past(q.ho == HO_HOLD);
    endproperty
    a_holdPin: assert property (p_holdPin) else $error("holdover pin wrong");
    property p_autoExit;
        (q.ho == HO_HOLD && q.ctrl.holdEnable && q.ctrl.autoExit && q.lock[0] &&
         !q.ctrl.forceHoldover && !railCond) |=> !holdover;
    endproperty
    a_autoExit: assert property (p_autoExit) else $error("no auto exit");
    property p_dacHold;
        (q.ho == HO_HOLD && q.ctrl.manualTuneSelect) |=>
            tuneDac == $past(q.tun.manualTuneValue);
    endproperty
    a_dacHold: assert property (p_dacHold) else $error("manual DAC not loaded");
    property p_half;
        dEdge[2] |=> q.half[2] != $past(q.half[2]);
    endproperty
    a_half: assert property (p_half) else $error("halved output did not toggle");
    property p_los;
        q.los[0] |-> $past(q.ctrl.lossDetectEnable);
    endproperty
    a_los: assert property (p_los) else $error("loss without enable");
    property p_rail;
        q.mux.sel[0] == SEL_RAIL |=> statusPin[0] == $past(q.dLow || q.dHigh);
    endproperty
    a_rail: assert property (p_rail) else $error("rail pin wrong");

endmodule

// *** rtl/lds_pkg.sv ***
// package for the lock detect and status monitor block
package lds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DAC_W  = 10;
    localparam int ERR_W  = 8;
    localparam int HITS_W = 16;
    localparam int TMR_W  = 8;
    localparam int RB_W   = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LOCK   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TUNE   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MUX    = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_DIV1   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DIV2   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_FBCFG  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_CALDIV = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] REG_RBLOAD = 8'h24;

    // timing figures and derived cycle counts (least times round up)
    localparam int CLK_MHZ = 25;
    localparam int CAL_NS  = 10000;
    localparam int CAL_CYC = (CAL_NS * CLK_MHZ + 999) / 1000;
    localparam int LOS0_NS = 1000;
    localparam int LOS1_NS = 2000;
    localparam int LOS2_NS = 4000;
    localparam int LOS3_NS = 8000;
    localparam logic [TMR_W-1:0] LOS0_CYC = TMR_W'((LOS0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] LOS1_CYC = TMR_W'((LOS1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] LOS2_CYC = TMR_W'((LOS2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] LOS3_CYC = TMR_W'((LOS3_NS * CLK_MHZ + 999) / 1000);

    localparam logic [DAC_W-1:0] DAC_NEAR = 10'h002;
    localparam logic [3:0]       PRE_MIN  = 4'h2;
    localparam logic [3:0]       PRE_MAX  = 4'h8;

    typedef enum logic [1:0] {HO_RUN = 2'b01, HO_HOLD = 2'b10} lds_ho_t;

    typedef enum logic [4:0] {
        SEL_LEVEL = 5'h00, SEL_LOCK1, SEL_LOCK2, SEL_BOTH, SEL_HOLD, SEL_DACLK,
        SEL_RAIL, SEL_LOW, SEL_HIGH, SEL_R1, SEL_N1, SEL_R2, SEL_N2,
        SEL_R1H, SEL_N1H, SEL_R2H, SEL_N2H, SEL_LOS, SEL_ACTIVE, SEL_RB
    } lds_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } lds_bus_t;

    typedef struct packed {
        logic [21:0] rsvd;
        logic        forcedLevel;
        logic [1:0]  lossTimeoutSetting;
        logic        lossDetectEnable;
        logic        railDetectEnable;
        logic        manualTuneSelect;
        logic        trackEnable;
        logic        autoExit;
        logic        forceHoldover;
        logic        holdEnable;
    } lds_ctrl_t;

    typedef struct packed {
        logic [HITS_W-1:0] lockHoldCount;
        logic [7:0]        rsvd;
        logic [ERR_W-1:0]  lockWindowSize;
    } lds_lock_t;

    typedef struct packed {
        logic [1:0]       rsvd;
        logic [DAC_W-1:0] manualTuneValue;
        logic [DAC_W-1:0] highTrip;
        logic [DAC_W-1:0] lowTrip;
    } lds_tune_t;

    typedef struct packed {
        logic [16:0]         rsvd;
        lds_sel_t [2:0]      sel;
    } lds_mux_t;

    typedef struct packed {
        logic [3:0]  rsvd;
        logic [13:0] n1;
        logic [13:0] r1;
    } lds_div1_t;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [3:0]  prescale;
        logic [11:0] r2;
    } lds_div2_t;

    typedef struct packed {
        logic [13:0] rsvd;
        logic [17:0] divide;
    } lds_fb_t;

    typedef struct packed {
        logic [9:0]       rsvd;
        logic [DAC_W-1:0] dacValue;
        logic             calActive;
        logic [2:0]       loss;
        logic             dacHigh;
        logic             dacLow;
        logic             dacRail;
        logic             dacLocked;
        logic             holdover;
        logic             lock2;
        logic             lock1Flag;
        logic             lock1Raw;
    } lds_stat_t;

    typedef struct packed {
        logic [13:0] r1;
        logic [13:0] n1;
        logic [11:0] r2;
        logic [3:0]  prescale;
        logic [17:0] n2;
    } lds_div_cfg_t;

    localparam lds_lock_t LOCK_RST = '{lockHoldCount: 16'h0010, rsvd: 8'h00,
                                       lockWindowSize: 8'h04};

endpackage

// *** sim/lds_div_model.sv ***
// divider pulse source standing in for the two loops' dividers
`timescale 1ns/1ns
module lds_div_model (
    input  wire logic       clk,
    input  wire logic [3:0] offset,
    output logic [3:0]      divPulse
);
    logic [3:0] cnt = 4'h0;
    logic [3:0] nPh;
    // free-running period of 16 clocks
    always_ff @(posedge clk) begin
        cnt <= cnt + 4'h1;
    end
    assign nPh = cnt - offset; // N lags R by offset clocks
    // pulses two clocks wide so the sync stage never misses one
    assign divPulse = {nPh < 4'h2, cnt < 4'h2, nPh < 4'h2, cnt < 4'h2};
endmodule

// *** sim/lds_lock_status_test.sv ***
// self-checking bench for the lock detect and status block
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module lds_lock_status_test;
    import lds_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    lds_bus_t          busReq = '0;
    logic [DATA_W-1:0] rdData;
    logic [3:0]        divPulse;
    logic [3:0]        offset = 4'h0;
    logic [1:0]        activeInput = 2'h1;
    logic [2:0]        clkIn = 3'h0;
    logic [DAC_W-1:0]  tuneLevel = 10'h200;
    logic [2:0]        statusPin;
    logic [DAC_W-1:0]  tuneDac;
    logic              holdover;
    lds_div_cfg_t      divCfg;
    logic [DATA_W-1:0] d;
    int                failures = 0;
    int                checks = 0;
    int                cyc = 0;
    always #20 clk = ~clk;
    lds_lock_status i_dut (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
        .divPulse(divPulse), .clkInPin(clkIn), .tuneLevel(tuneLevel),
        .activeInput(activeInput), .statusPin(statusPin), .tuneDac(tuneDac),
        .holdover(holdover), .divCfg(divCfg));
    lds_div_model i_div (.clk(clk), .offset(offset), .divPulse(divPulse));
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk) busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk) busReq <= '0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk) busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) busReq <= '0;
        #1 v = rdData;
    endtask
    // pin is only looked at off the edge, once it has settled
    task automatic wait_pin(input logic lvl);
        #1;
        for (int i = 0; i < 300 && statusPin[2] !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic t_reset();
        rd(REG_LOCK, d);
        `CHK("lock reset", 32'h00100004, d)
        rd(8'h40, d);
        `CHK("unmapped", 32'h00000000, d)
        `CHK("prescale", 4'h2, divCfg.prescale)
        $display("t_reset done");
    endtask
    task automatic t_lock();
        wr(REG_LOCK, 32'h00030004);
        wr(REG_MUX, 32'h00000c00); // lock pin shows both loops
        wait_pin(1'b1);
        `CHK("lock both", 1'b1, statusPin[2])
        offset <= 4'h8;
        wait_pin(1'b0);
        `CHK("lock lost", 1'b0, statusPin[2])
        offset <= 4'h0;
        wait_pin(1'b1);
        `CHK("relock", 1'b1, statusPin[2])
        $display("t_lock done");
    endtask
    task automatic t_pins();
        int                n;
        int                m;
        logic [DATA_W-1:0] v;
        wr(REG_MUX, 32'h00000240); // pin0 level, pin1 active
        wr(REG_CTRL, 32'h00000200);
        repeat (2) @(posedge clk);
        #1;
        `CHK("forced level", 1'b1, statusPin[0])
        `CHK("active in", 1'b1, statusPin[1])
        wr(REG_CTRL, 32'h00000000);
        repeat (2) @(posedge clk);
        #1;
        `CHK("level low", 1'b0, statusPin[0])
        wr(REG_MUX, 32'h000001a9); // pin0 raw R1, pin1 halved R1
        n = 0;
        m = 0;
        // four periods of 16 clocks: four pulses, half the time high
        repeat (64) begin
            @(posedge clk);
            #1;
            n += statusPin[0];
            m += statusPin[1];
        end
        `CHK("raw pulses", 4, n)
        `CHK("halved high", 32, m)
        rd(REG_STATUS, d);
        wr(REG_MUX, 32'h00000260); // pin1 readback
        wr(REG_RBLOAD, 32'h00000000);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk);
            #1;
            v[i] = statusPin[1];
        end
        `CHK("readback", d, v)
        $display("t_pins done");
    endtask
    task automatic t_loss();
        wr(REG_MUX, 32'h00000011); // pin0 loss of input 0
        wr(REG_CTRL, 32'h00000040); // enable, shortest timeout
        repeat (40) @(posedge clk);
        #1;
        `CHK("loss set", 1'b1, statusPin[0])
        // a rising input edge every 8 clocks keeps the timer short
        repeat (12) begin
            @(posedge clk) clkIn <= ~clkIn;
            repeat (3) @(posedge clk);
        end
        #1;
        `CHK("loss clear", 1'b0, statusPin[0])
        wr(REG_CTRL, 32'h00000000);
        repeat (40) @(posedge clk);
        #1;
        `CHK("loss off", 1'b0, statusPin[0])
        $display("t_loss done");
    endtask
    task automatic t_hold();
        wr(REG_TUNE, 32'h155003ff);
        wr(REG_MUX, 32'h00001086); // pin0 rail, pin1 and pin2 holdover
        wr(REG_CTRL, 32'h0000001b); // force with tracking and manual
        repeat (3) @(posedge clk);
        #1;
        `CHK("holdover", 1'b1, holdover)
        `CHK("hold pin", 1'b1, statusPin[2])
        `CHK("hold pin1", 1'b1, statusPin[1])
        `CHK("rail pin", 1'b1, statusPin[0])
        `CHK("manual dac", 10'h155, tuneDac)
        rd(REG_STATUS, d);
        `CHK("lock1 masked", 1'b0, d[1])
        `CHK("dac low", 1'b1, d[6])
        `CHK("dac high", 1'b1, d[7])
        wr(REG_MUX, 32'h00000486); // lock pin shows loop one
        repeat (2) @(posedge clk);
        #1;
        `CHK("lock pin masked", 1'b0, statusPin[2])
        wr(REG_CTRL, 32'h0000001d); // auto exit, force dropped
        repeat (3) @(posedge clk);
        #1;
        `CHK("auto exit", 1'b0, holdover)
        `CHK("lock pin back", 1'b1, statusPin[2])
        wr(REG_CTRL, 32'h0000001b);
        repeat (3) @(posedge clk);
        #1;
        `CHK("hold again", 1'b1, holdover)
        wr(REG_CTRL, 32'h00000000);
        repeat (3) @(posedge clk);
        #1;
        `CHK("hold exit", 1'b0, holdover)
        @(posedge clk) tuneLevel <= 10'h157;
        wr(REG_CTRL, 32'h00000008); // tracking only
        repeat (48) @(posedge clk);
        #1;
        `CHK("tracked dac", 10'h157, tuneDac)
        rd(REG_STATUS, d);
        `CHK("dac locked", 1'b1, d[4])
        wr(REG_CTRL, 32'h0000000b); // holdover keeps the tracked value
        @(posedge clk) tuneLevel <= 10'h100;
        repeat (48) @(posedge clk);
        #1;
        `CHK("held tracked dac", 10'h157, tuneDac)
        wr(REG_CTRL, 32'h00000000);
        rd(REG_STATUS, d);
        `CHK("dac unlocked", 1'b0, d[4])
        $display("t_hold done");
    endtask
    task automatic t_cal();
        wr(REG_CALDIV, 32'h00000005);
        wr(REG_FBCFG, 32'h0003ffff);
        repeat (2) @(posedge clk);
        #1;
        `CHK("cal divide", 18'h00005, divCfg.n2)
        repeat (CAL_CYC + 10) @(posedge clk);
        #1;
        `CHK("normal divide", 18'h3ffff, divCfg.n2)
        $display("t_cal done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_lock();
        t_pins();
        t_loss();
        t_hold();
        t_cal();
        conclude();
    end
endmodule
